// ==== bench/dsc_core_model.sv ====
`timescale 1ns/100ps
module dsc_core_model
  import dsc_pkg::*;
(
  input wire logic pclk,
  output dsc_op_type ps_op,
  output dsc_op_type rs_op,
  output logic [15:0] ps_push_data,
  output logic [20:0] rs_push_data
);
  initial begin
    ps_op = 2'h0;
    rs_op = 2'h0;
    ps_push_data = 16'h0000;
    rs_push_data = 21'h000000;
  end
  // both stacks together
  // One instruction steps both stacks for exactly one cycle.
  task automatic step(input dsc_op_type ps, input dsc_op_type rs,
                      input logic [15:0] pd, input logic [20:0] rd);
    @(posedge pclk);
    ps_op <= ps;
    rs_op <= rs;
    ps_push_data <= pd;
    rs_push_data <= rd;
    @(posedge pclk);
    ps_op <= 2'h0;
    rs_op <= 2'h0;
    ps_push_data <= ~pd;
    rs_push_data <= ~rd;
  endtask
endmodule

// ==== bench/tb_dual_stack_controller.sv ====
`timescale 1ns/100ps
module tb_dual_stack_controller
  import dsc_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, irqs;
  dsc_op_type ps_op, rs_op;
  logic [15:0] ps_push_data, top_out, next_out;
  logic [20:0] rs_push_data, rs_top_out;
  logic ps_ovf_irq, ps_unf_irq, rs_ovf_irq, rs_unf_irq;
  int fail_count = 0;
  int check_count = 0;
  localparam dsc_op_type PU = 2'h2;
  localparam dsc_op_type PO = 2'h1;
  localparam dsc_op_type NO = 2'h0;
  localparam logic [11:0] A_PTR = {2'h0, DSC_ADDR_PTR};
  localparam logic [11:0] A_UNF = {2'h0, DSC_ADDR_UNF};
  localparam logic [11:0] A_LIM = {2'h0, DSC_ADDR_LIM};
  localparam logic [11:0] A_IRQ = {2'h0, DSC_ADDR_IRQ};
  localparam logic [11:0] A_TN = {2'h0, DSC_ADDR_TOS};
  logic [7:0] st [4] = '{8'h5F, 8'hBF, 8'h7F, 8'hFF};
  logic [7:0] ex [4] = '{8'h40, 8'h80, 8'h00, 8'h00};
  assign irqs = {28'h0, ps_ovf_irq, ps_unf_irq, rs_ovf_irq, rs_unf_irq};

  dsc_top DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ps_op(ps_op), .rs_op(rs_op),
    .ps_push_data(ps_push_data), .rs_push_data(rs_push_data),
    .top_out(top_out), .next_out(next_out), .rs_top_out(rs_top_out),
    .ps_ovf_irq(ps_ovf_irq), .ps_unf_irq(ps_unf_irq),
    .rs_ovf_irq(rs_ovf_irq), .rs_unf_irq(rs_unf_irq)
  );
  dsc_core_model core (
    .pclk(pclk), .ps_op(ps_op), .rs_op(rs_op),
    .ps_push_data(ps_push_data), .rs_push_data(rs_push_data)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // The tests take well under 2000 cycles; this cuts a hang short.
  initial begin
    #20000;
    fail_count++;
    summarize();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(A_PTR, 32'h0);
    rdchk(A_UNF, 32'h0707);
    rdchk(A_IRQ, 32'h0);
    rdchk(A_TN, 32'hFFFF0000);
    rdchk(12'h100, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b0, A_LIM, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("Test reset done");
    core.step(PU, PU, 16'hA5A5, 21'h1ABCD);
    core.step(PU, NO, 16'h5A5A, 21'h0);
    rdchk(A_PTR, 32'h0102);
    rdchk(A_TN, 32'hA5A55A5A);
    check({11'h0, rs_top_out}, 32'h1ABCD);
    core.step(PO, PO, 16'h0, 21'h0);
    rdchk(A_PTR, 32'h0001);
    rdchk(A_TN, 32'h0000A5A5);
    check({11'h0, rs_top_out}, 32'h00FFFF);
    $display("Test push pop done");
    apb(1'b1, A_PTR, 32'hFEFE);
    core.step(PU, PU, 16'h1111, 21'h2222);
    rdchk(A_IRQ, 32'h000A);
    check(irqs, 32'hA);
    core.step(PU, PU, 16'h3333, 21'h4444);
    rdchk(A_PTR, 32'h0000);
    apb(1'b1, A_IRQ, 32'h0);
    rdchk(A_IRQ, 32'h000B);
    check(irqs, 32'hA);
    apb(1'b1, A_PTR, 32'h0000);
    rdchk(A_IRQ, 32'h0);
    check(irqs, 32'h0);
    core.step(PO, PO, 16'h0, 21'h0);
    rdchk(A_PTR, 32'hFFFF);
    rdchk(A_IRQ, 32'h0015);
    check(irqs, 32'h5);
    $display("Test errors done");
    apb(1'b1, A_UNF, 32'h0706);
    apb(1'b1, A_PTR, 32'h0080);
    core.step(PO, NO, 16'h0, 21'h0);
    rdchk(A_IRQ, 32'h0004);
    apb(1'b1, A_LIM, 32'hFF10);
    apb(1'b1, A_PTR, 32'h0080);
    core.step(PO, NO, 16'h0, 21'h0);
    rdchk(A_IRQ, 32'h0);
    $display("Test start flag done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, A_UNF, {21'h0, i[1:0], 6'h01, i[1:0], 1'b1});
      apb(1'b1, A_PTR, {16'h0, st[i], st[i]});
      core.step(PU, PU, 16'h0, 21'h0);
      rdchk(A_PTR, {16'h0, ex[i], ex[i]});
      apb(1'b0, A_IRQ, 32'h0);
      check({31'h0, rd[0]}, 32'h1);
    end
    $display("Test substacks done");
    summarize();
  end
endmodule

// ==== verilog/dsc_ctrl.sv ====
`timescale 1ns/100ps
module dsc_ctrl
  import dsc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire dsc_op_type op,
  input wire logic ptr_we,
  input wire logic [7:0] ptr_wdata,
  input wire logic [7:0] ovf_lim,
  input wire logic [7:0] unf_lim,
  output logic [7:0] ptr,
  output logic [7:0] mem_addr,
  output dsc_err_type err
);

  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  dsc_err_type err_reg;
  dsc_err_type err_next;
  wire logic [1:0] size_sel = unf_lim[DSC_SIZE_LSB +: 2];
  wire logic start_flag = unf_lim[DSC_START_BIT];
  wire logic [7:0] frz_mask = size_sel == 2'b00 ? 8'hE0 :
                              size_sel == 2'b01 ? 8'hC0 :
                              size_sel == 2'b10 ? 8'h80 : 8'h00;
  wire logic [7:0] span = ~frz_mask;
  wire logic [7:0] ptr_inc = ptr_reg + 8'h01;
  wire logic [7:0] ptr_dec = ptr_reg - 8'h01;
  wire logic lim_low = (ovf_lim & span) < ((span >> 1) + 8'h01);
  wire logic at_bottom = start_flag | lim_low;
  wire logic [7:0] start_ofs = at_bottom ? 8'h00 : ((span >> 1) + 8'h01);
  wire logic [7:0] ovf_addr = (ptr_reg & frz_mask) | (ovf_lim & span);
  wire logic [7:0] unf_addr = (ptr_reg & frz_mask) |
                              (((unf_lim & 8'hF8) + start_ofs) & span);
  wire logic [7:0] top_addr = (ptr_reg & frz_mask) | span;

  assign ptr = ptr_reg;
  // pop reads at pointer minus one.
  assign mem_addr = op.pop ? ((ptr_reg & frz_mask) | (ptr_dec & span))
                           : ptr_reg;

  always_comb begin
    ptr_next = ptr_reg;
    err_next = err_reg;
    if (op.push && !op.pop) begin
      ptr_next = (ptr_reg & frz_mask) | (ptr_inc & span);
    end else if (op.pop && !op.push) begin
      ptr_next = (ptr_reg & frz_mask) | (ptr_dec & span);
    end
    if (op.push && ptr_next == ovf_addr) begin
      err_next.ovf = 1'b1;
    end
    if (op.pop && ptr_reg == unf_addr) begin
      err_next.unf = 1'b1;
    end
    if ((op.push || op.pop) && mem_addr == top_addr) begin
      err_next.fatal = 1'b1;
    end
    if (ptr_we) begin
      ptr_next = ptr_wdata;
      err_next = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_reg <= 8'h00;
      err_reg <= '0;
    end else begin
      ptr_reg <= ptr_next;
      err_reg <= err_next;
    end
  end
  assign err = err_reg;

  // Assertions.
  wrap_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    op.push && !op.pop && !ptr_we |=> ((ptr_reg & frz_mask) ==
      ($past(ptr_reg) & $past(frz_mask))))
    else $error("substack number changed on push");
  push_incr_a: assert property (@(posedge pclk) disable iff (!presetn)
    op.push && !op.pop && !ptr_we && size_sel == 2'b11 |=>
      ptr_reg == $past(ptr_reg) + 8'h01)
    else $error("pointer not incremented on push");
  pop_decr_a: assert property (@(posedge pclk) disable iff (!presetn)
    op.pop && !op.push && !ptr_we && size_sel == 2'b11 |=>
      ptr_reg == $past(ptr_reg) - 8'h01)
    else $error("pointer not decremented on pop");
  wr_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    ptr_we |=> err == '0)
    else $error("flags not cleared by pointer write");
  fatal_top_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ptr_we && op.push && !op.pop && (ptr_reg & span) == span
      |=> err.fatal)
    else $error("fatal not flagged at top");
endmodule

// ==== verilog/dsc_pkg.sv ====
package dsc_pkg;

  // Register byte addresses, printed index times four.
  localparam logic [7:0] DSC_IDX_PTR = 8'h09;
  localparam logic [7:0] DSC_IDX_OVF = 8'h0B;
  localparam logic [7:0] DSC_IDX_UNF = 8'h0A;
  localparam logic [7:0] DSC_IDX_PAGE = 8'h0C;
  localparam logic [7:0] DSC_IDX_IRQ = 8'h10;
  localparam logic [7:0] DSC_IDX_TOS = 8'h18;
  localparam logic [9:0] DSC_ADDR_PTR = {DSC_IDX_PTR, 2'b00};
  localparam logic [9:0] DSC_ADDR_LIM = {DSC_IDX_OVF, 2'b00};
  localparam logic [9:0] DSC_ADDR_UNF = {DSC_IDX_UNF, 2'b00};
  localparam logic [9:0] DSC_ADDR_PAGE = {DSC_IDX_PAGE, 2'b00};
  localparam logic [9:0] DSC_ADDR_IRQ = {DSC_IDX_IRQ, 2'b00};
  localparam logic [9:0] DSC_ADDR_TOS = {DSC_IDX_TOS, 2'b00};

  localparam logic [15:0] DSC_PTR_RST = 16'h0000;
  localparam logic [15:0] DSC_OVF_RST = 16'hFFFF;
  localparam logic [15:0] DSC_UNF_RST = 16'h0707;
  localparam logic [15:0] DSC_TOP_RST = 16'h0000;
  localparam logic [15:0] DSC_NEXT_RST = 16'hFFFF;
  localparam logic [15:0] DSC_IDX_RST = 16'hFFFF;
  localparam logic [4:0] DSC_PAGE_RST = 5'h00;

  localparam int DSC_RET_LSB = 8;
  localparam int DSC_START_BIT = 0;
  localparam int DSC_SIZE_LSB = 1;
  localparam int DSC_IRQ_FATAL = 0;
  localparam int DSC_IRQ_PS_LSB = 1;
  localparam int DSC_IRQ_RS_LSB = 3;

  typedef struct packed {
    logic push;
    logic pop;
  } dsc_op_type;

  typedef struct packed {
    logic ovf;
    logic unf;
    logic fatal;
  } dsc_err_type;

endpackage

// ==== verilog/dsc_top.sv ====
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/100ps
// Overview of operation
// - Parameter stack memory 256 by 16.
// - Top two parameter entries in registers.
// - Return stack 21 bits, index plus page.
// - Both stacks operate in one cycle.
// - Two identical controller copies.
// - Push writes at pointer, then increments.
// - Pop reads pointer minus one, decrements.
// - First push after start lands at zero.
// - Substacks of 32, 64, 128 or whole.
// - Size from underflow bits 1-2, 9-10.
// - Upper pointer bits frozen as substack number.
// - Start flags at underflow bits 0, 8.
// - Start flag one bottom, zero middle.
// - Low overflow limit forces bottom start.
// - Addressing wraps; full push overwrites.
// - Empty pop completes, returns memory contents.
// - Limit crossings raise flags and requests.
// - Error flags read in low five bits.
// - Pointer write clears all error flags.
// - Top location access flags fatal, no request.
// - Fatal errors ORed into bit 0.
// - Pointer register resets to zero.
// - Overflow limits reset to all ones.
module dsc_top
  import dsc_pkg::*;
#(
  parameter int DEPTH = 256,
  parameter int PWIDTH = 16,
  parameter int PGWIDTH = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dsc_op_type ps_op,
  input wire dsc_op_type rs_op,
  input wire logic [PWIDTH-1:0] ps_push_data,
  input wire logic [PWIDTH+PGWIDTH-1:0] rs_push_data,
  output logic [PWIDTH-1:0] top_out,
  output logic [PWIDTH-1:0] next_out,
  output logic [PWIDTH+PGWIDTH-1:0] rs_top_out,
  output logic ps_ovf_irq,
  output logic ps_unf_irq,
  output logic rs_ovf_irq,
  output logic rs_unf_irq
);

  localparam int RW = PWIDTH + PGWIDTH;

  initial begin
    if (DEPTH != 256 || PWIDTH != 16 || PGWIDTH != 5) begin
      $error("dsc_top supports only 256 x 16 and 5-bit page");
    end
  end

  logic [PWIDTH-1:0] ps_mem [DEPTH];
  logic [RW-1:0] rs_mem [DEPTH];

  logic [15:0] overflow_limit_reg;
  logic [15:0] underflow_limit_reg;
  logic [PWIDTH-1:0] top_reg;
  logic [PWIDTH-1:0] next_reg;
  logic [PWIDTH-1:0] idx_reg;
  logic [PGWIDTH-1:0] index_page_reg;
  logic [31:0] prdata_reg;
  logic [7:0] ps_ptr;
  logic [7:0] rs_ptr;
  logic [7:0] ps_addr;
  logic [7:0] rs_addr;
  dsc_err_type ps_err;
  dsc_err_type rs_err;

  wire logic acc = psel && penable;
  wire logic wr = acc && pwrite;
  wire logic [9:0] word_addr = paddr[11:2];
  wire logic setup_rd = psel && !penable && !pwrite;
  wire logic hit_ptr = word_addr == DSC_ADDR_PTR[9:0] >> 2;
  wire logic hit_ovf = word_addr == DSC_ADDR_LIM[9:0] >> 2;
  wire logic hit_unf = word_addr == DSC_ADDR_UNF[9:0] >> 2;
  wire logic hit_page = word_addr == DSC_ADDR_PAGE[9:0] >> 2;
  wire logic hit_irq = word_addr == DSC_ADDR_IRQ[9:0] >> 2;
  wire logic hit_tos = word_addr == DSC_ADDR_TOS[9:0] >> 2;
  wire logic mapped = hit_ptr | hit_ovf | hit_unf | hit_page | hit_irq |
                      hit_tos;
  wire logic ptr_wr = wr && hit_ptr;
  wire logic [4:0] irq_flags = {rs_err.unf, rs_err.ovf, ps_err.unf,
                                ps_err.ovf, ps_err.fatal | rs_err.fatal};
  wire logic [31:0] rd_mux =
    hit_ptr ? {16'h0000, rs_ptr, ps_ptr} :
    hit_unf ? {16'h0000, underflow_limit_reg} :
    hit_page ? {27'h0000000, index_page_reg} :
    hit_irq ? {27'h0000000, irq_flags} :
    hit_tos ? {next_reg, top_reg} : 32'h00000000;

  assign pready = 1'b1;
  assign pslverr = acc && (!mapped || (!pwrite && hit_ovf));
  assign prdata = prdata_reg;

  dsc_ctrl u_ps (
    .pclk(pclk),
    .presetn(presetn),
    .op(ps_op),
    .ptr_we(ptr_wr),
    .ptr_wdata(pwdata[7:0]),
    .ovf_lim(overflow_limit_reg[7:0]),
    .unf_lim(underflow_limit_reg[7:0]),
    .ptr(ps_ptr),
    .mem_addr(ps_addr),
    .err(ps_err)
  );
  dsc_ctrl u_rs (
    .pclk(pclk),
    .presetn(presetn),
    .op(rs_op),
    .ptr_we(ptr_wr),
    .ptr_wdata(pwdata[15:8]),
    .ovf_lim(overflow_limit_reg[15:8]),
    .unf_lim(underflow_limit_reg[15:8]),
    .ptr(rs_ptr),
    .mem_addr(rs_addr),
    .err(rs_err)
  );

  assign ps_ovf_irq = ps_err.ovf;
  assign ps_unf_irq = ps_err.unf;
  assign rs_ovf_irq = rs_err.ovf;
  assign rs_unf_irq = rs_err.unf;
  assign top_out = top_reg;
  assign next_out = next_reg;
  assign rs_top_out = {index_page_reg, idx_reg};

  // overflow limit reset all ones.
  // Read data is latched in the setup cycle so it stands at the access edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_limit_reg <= DSC_OVF_RST;
      underflow_limit_reg <= DSC_UNF_RST;
      prdata_reg <= 32'h00000000;
    end else begin
      if (wr && hit_ovf) begin
        overflow_limit_reg <= pwdata[15:0];
      end
      if (wr && hit_unf) begin
        underflow_limit_reg <= pwdata[15:0];
      end
      if (setup_rd) begin
        prdata_reg <= rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      top_reg <= DSC_TOP_RST;
      next_reg <= DSC_NEXT_RST;
      idx_reg <= DSC_IDX_RST;
      index_page_reg <= DSC_PAGE_RST;
    end else begin
      if (wr && hit_tos) begin
        top_reg <= pwdata[15:0];
        next_reg <= pwdata[31:16];
      end else if (ps_op.push && !ps_op.pop) begin
        top_reg <= ps_push_data;
        next_reg <= top_reg;
      end else if (ps_op.pop && !ps_op.push) begin
        top_reg <= next_reg;
        next_reg <= ps_mem[ps_addr];
      end
      if (wr && hit_page) begin
        index_page_reg <= pwdata[PGWIDTH-1:0];
      end else if (rs_op.push && !rs_op.pop) begin
        {index_page_reg, idx_reg} <= rs_push_data;
      end else if (rs_op.pop && !rs_op.push) begin
        {index_page_reg, idx_reg} <= rs_mem[rs_addr];
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (ps_op.push && !ps_op.pop) begin
      ps_mem[ps_addr] <= next_reg;
    end
    if (rs_op.push && !rs_op.pop) begin
      rs_mem[rs_addr] <= {index_page_reg, idx_reg};
    end
  end

  rst_limit_a: assert property (@(posedge pclk)
    $rose(presetn) |-> overflow_limit_reg == 16'hFFFF &&
      ps_ptr == 8'h00)
    else $error("limit or pointer reset value wrong");
  fatal_or_a: assert property (@(posedge pclk) disable iff (!presetn)
    hit_irq && setup_rd |=>
      prdata[0] == $past(ps_err.fatal | rs_err.fatal))
    else $error("fatal bit not ORed into bit 0");
  ibc_ro_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_irq && !ps_op.push && !ps_op.pop && !rs_op.push &&
      !rs_op.pop |=> irq_flags == $past(irq_flags))
    else $error("error flags changed by write");
endmodule
